// ===== logic/cpu_clock_power_mgmt_pkg.sv
// What this block does
// - Core zone logic advances only with core enable
// - Timer zone advances only with timer enable
// - Processor clock drives core and timer, not scan
// - Clock-off status captured into debug status
// - Each tick increments base, decrements a nonzero interval or reloads it
// - Tick held high updates timers every cycle
// - External enable mirror follows its state bit
// - Critical enable mirror follows its state bit
// - Timer request is OR of timer interrupts
// - Watchdog request is OR of reset selections
// - Sleep request only after work drains
// - Mirrors drop one cycle before sleep request
package cpu_clock_power_mgmt_pkg;

    // Timer widths
    localparam int TB_W    = 64;
    localparam int PIT_W   = 32;
    localparam int BITSEL_W = 6;

    // Values after reset
    localparam logic [TB_W-1:0]  TB_RESET  = 64'h0000_0000_0000_0000;
    localparam logic [PIT_W-1:0] PIT_RESET = 32'h0000_0000;
    localparam logic [2:0]       WDR_RESET = 3'h0;

    // Bit positions in the pending watchdog reset vector
    localparam int WDR_CORE_POS = 0;
    localparam int WDR_CHIP_POS = 1;
    localparam int WDR_SYS_POS  = 2;

    typedef enum logic [1:0] {
        RST_NONE,
        RST_CORE,
        RST_CHIP,
        RST_SYSTEM
    } reset_sel_t;

    typedef enum {
        ST_RUN,
        ST_DRAIN,
        ST_SLEEP,
        ST_WAKE
    } sleep_state_t;

    // Machine state bits visible to this block
    typedef struct packed {
        logic ext;
        logic crit;
        logic waitEn;
    } msr_t;

    // Timer interrupt sources, also used for clears
    typedef struct packed {
        logic interval_down_counter;
        logic fixed_interval_timer;
        logic wdt;
    } timer_irq_t;

    typedef struct packed {
        logic [PIT_W-1:0]    reload;
        logic                autoReload;
        logic [BITSEL_W-1:0] fitBit;
        logic [BITSEL_W-1:0] wdtBit;
        reset_sel_t          resetSel;
    } timer_cfg_t;

    typedef struct packed {
        logic coreOff;
        logic scanEn;
    } debug_status_t;

endpackage

// ===== logic/cpu_clock_power_mgmt_port.sv
`timescale 1ns/1ps
module cpu_clock_power_mgmt_port (
    input  wire logic                                   clk_sys,
    input  wire logic                                   srst,
    input  wire logic                                   coreZoneClockEnable,
    input  wire logic                                   timerZoneClockEnable,
    input  wire logic                                   scanZoneClockEnable,
    input  wire logic                                   coreClockOffStatus,
    input  wire logic                                   timerTick,
    input  wire logic                                   debugHaltIn,
    input  wire logic                                   msrWrite,
    input  wire cpu_clock_power_mgmt_pkg::msr_t         msrData,
    input  wire logic                                   pipelineBusy,
    input  wire logic                                   wakeEvent,
    input  wire logic                                   pitLoad,
    input  wire cpu_clock_power_mgmt_pkg::timer_cfg_t   timerCfg,
    input  wire cpu_clock_power_mgmt_pkg::timer_irq_t   irqClear,
    output logic                                        extIrqEnableOut,
    output logic                                        critIrqEnableOut,
    output logic                                        timerIrqReq,
    output logic                                        watchdogResetReq,
    output logic                                        sleepReq,
    output cpu_clock_power_mgmt_pkg::debug_status_t     debugStatus,
    output logic [cpu_clock_power_mgmt_pkg::TB_W-1:0]   timeBase,
    output logic [cpu_clock_power_mgmt_pkg::PIT_W-1:0]  intervalCount,
    output cpu_clock_power_mgmt_pkg::timer_irq_t        pendingIrq
);
    import cpu_clock_power_mgmt_pkg::*;

    logic srstQ;

    default clocking cb @(posedge clk_sys); endclocking
    // Reset still reads high on the edge that releases it, so the checks
    // stay off for one more edge
    default disable iff (srst || srstQ);

    sleep_state_t state;
    msr_t         msr;
    logic [2:0]   wdResetPend;
    logic         tick;
    logic         wakeSrc;
    logic         pitEvent;
    logic         fitEvent;
    logic         wdtEvent;
    logic [TB_W-1:0] tbNext;

    // clk_sys is the processor clock; scan logic lives elsewhere
    assign tick    = timerZoneClockEnable & timerTick;
    assign tbNext  = timeBase + TB_W'(1);
    assign pitEvent = tick & (intervalCount == PIT_W'(1));
    // Rising edge of the selected time base bit marks an interval event
    assign fitEvent = tick & tbNext[timerCfg.fitBit]
                      & ~timeBase[timerCfg.fitBit];
    assign wdtEvent = tick & tbNext[timerCfg.wdtBit]
                      & ~timeBase[timerCfg.wdtBit];
    assign wakeSrc = wakeEvent | (|pendingIrq) | (|wdResetPend)
                     | debugHaltIn;

    // Sleep sequencing, frozen while the core zone is gated
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_RUN;
        end else if (coreZoneClockEnable) begin
            unique case (state)
                ST_RUN: begin
                    if (msr.waitEn) begin
                        state <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    // Earlier work must finish before asking to sleep
                    if (!pipelineBusy) begin
                        state <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wakeSrc) begin
                        state <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Machine state bits; wake clears the wait enable
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            msr <= '0;
        end else if (coreZoneClockEnable) begin
            if (state == ST_WAKE) begin
                msr.waitEn <= 1'b0;
                if (msrWrite) begin
                    msr.ext  <= msrData.ext;
                    msr.crit <= msrData.crit;
                end
            end else if (msrWrite) begin
                msr <= msrData;
            end
        end
    end

    // Outbound pins; in the wake cycle the mirrors drop while sleep
    // request stays one more cycle, so the far side must register them
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            extIrqEnableOut  <= 1'b0;
            critIrqEnableOut <= 1'b0;
            timerIrqReq      <= 1'b0;
            sleepReq         <= 1'b0;
        end else begin
            extIrqEnableOut  <= msr.ext & (state != ST_WAKE);
            critIrqEnableOut <= msr.crit & (state != ST_WAKE);
            timerIrqReq <= (|pendingIrq) & (state != ST_WAKE);
            sleepReq <= (state == ST_SLEEP) | (state == ST_WAKE);
        end
    end

    // Time base counts every enabled tick
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            timeBase <= TB_RESET;
        end else if (tick) begin
            timeBase <= tbNext;
        end
    end

    // Interval counter stops at zero unless auto reload is set
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            intervalCount <= PIT_RESET;
        end else if (pitLoad) begin
            intervalCount <= timerCfg.reload;
        end else if (tick && intervalCount != PIT_RESET) begin
            if (pitEvent && timerCfg.autoReload) begin
                intervalCount <= timerCfg.reload;
            end else begin
                intervalCount <= intervalCount - PIT_W'(1);
            end
        end
    end

    // Sticky timer interrupts; a new event beats a same-cycle clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pendingIrq <= '0;
        end else begin
            pendingIrq.interval_down_counter <= (pendingIrq.interval_down_counter & ~irqClear.interval_down_counter) | pitEvent;
            pendingIrq.fixed_interval_timer <= (pendingIrq.fixed_interval_timer & ~irqClear.fixed_interval_timer) | fitEvent;
            pendingIrq.wdt <= (pendingIrq.wdt & ~irqClear.wdt) | wdtEvent;
        end
    end

    // Second watchdog timeout with the first unserviced asks for reset;
    // the request holds until a reset clears it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wdResetPend <= WDR_RESET;
        end else if (wdtEvent && pendingIrq.wdt) begin
            unique case (timerCfg.resetSel)
                RST_NONE:   ;
                RST_CORE:   wdResetPend[WDR_CORE_POS] <= 1'b1;
                RST_CHIP:   wdResetPend[WDR_CHIP_POS] <= 1'b1;
                RST_SYSTEM: wdResetPend[WDR_SYS_POS]  <= 1'b1;
            endcase
        end
    end

    // Reset request pin is the OR of the chosen reset kinds
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            watchdogResetReq <= 1'b0;
        end else begin
            watchdogResetReq <= |wdResetPend;
        end
    end

    // Debug status sampled every cycle, even with the core gated
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            debugStatus <= '0;
        end else begin
            debugStatus.coreOff <= coreClockOffStatus;
            debugStatus.scanEn  <= scanZoneClockEnable;
        end
    end

    // Reset seen one edge ago, used by the checks only
    always_ff @(posedge clk_sys) begin
        srstQ <= srst;
    end

    property p_core_gate;
        !coreZoneClockEnable |=> $stable(state) && $stable(msr);
    endproperty
    a_core_gate: assert property (p_core_gate)
        else $error("core state moved while core zone gated");

    property p_timer_gate;
        !timerZoneClockEnable |=> $stable(timeBase);
    endproperty
    a_timer_gate: assert property (p_timer_gate)
        else $error("time base moved while timer zone gated");

    property p_tick_step;
        tick && !pitLoad && intervalCount > PIT_W'(1)
        |=> timeBase == $past(timeBase) + TB_W'(1)
            && intervalCount == $past(intervalCount) - PIT_W'(1);
    endproperty
    a_tick_step: assert property (p_tick_step)
        else $error("tick did not step both timers");

    property p_full_rate;
        tick [*3] |=> timeBase == $past(timeBase, 3) + TB_W'(3);
    endproperty
    a_full_rate: assert property (p_full_rate)
        else $error("timers not updated every cycle under held tick");

    property p_ext_mirror;
        state != ST_WAKE |=> extIrqEnableOut == $past(msr.ext);
    endproperty
    a_ext_mirror: assert property (p_ext_mirror)
        else $error("external enable mirror wrong");

    property p_crit_mirror;
        state != ST_WAKE |=> critIrqEnableOut == $past(msr.crit);
    endproperty
    a_crit_mirror: assert property (p_crit_mirror)
        else $error("critical enable mirror wrong");

    property p_timer_or;
        state != ST_WAKE |=> timerIrqReq == (|$past(pendingIrq));
    endproperty
    a_timer_or: assert property (p_timer_or)
        else $error("timer request is not OR of pending timers");

    property p_wd_or;
        wdResetPend != WDR_RESET |=> watchdogResetReq;
    endproperty
    a_wd_or: assert property (p_wd_or)
        else $error("watchdog reset request missing");

    property p_drain_first;
        state == ST_DRAIN && pipelineBusy |=> !sleepReq;
    endproperty
    a_drain_first: assert property (p_drain_first)
        else $error("sleep requested before work drained");

    property p_early_drop;
        !srstQ && $fell(sleepReq)
        |-> $past(!extIrqEnableOut && !critIrqEnableOut && !timerIrqReq);
    endproperty
    a_early_drop: assert property (p_early_drop)
        else $error("mirrors not dropped a cycle before sleep request");

    property p_dbg_capture;
        1'b1 |=> debugStatus.coreOff == $past(coreClockOffStatus);
    endproperty
    a_dbg_capture: assert property (p_dbg_capture)
        else $error("clock-off status not captured");

endmodule

// ===== tb/power_mgmt_model.sv
`timescale 1ns/1ps
// Far-side clock and power controller, behavioural
module power_mgmt_model (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic sleepReq,
    input  wire logic timerIrqReq,
    input  wire logic watchdogResetReq,
    input  wire logic extIrqEnableOut,
    input  wire logic critIrqEnableOut,
    input  wire logic intIn,
    input  wire logic extResetReq,
    input  wire logic debugHaltIn,
    input  wire logic timerGate,
    output logic      coreZoneClockEnable,
    output logic      timerZoneClockEnable,
    output logic      scanZoneClockEnable,
    output logic      coreClockOffStatus
);
    logic eeQ, ceQ, irqQ, sleepQ, wake;
    // Scan zone never gated; timer zone on unless the bench gates it
    assign scanZoneClockEnable  = 1'h1;
    assign timerZoneClockEnable = timerGate;
    // Registered first, since they drop a cycle early on wake
    always_ff @(posedge clk_sys) begin
        eeQ    <= extIrqEnableOut;
        ceQ    <= critIrqEnableOut;
        irqQ   <= timerIrqReq;
        sleepQ <= sleepReq;
    end
    // One interrupt line serves both enable kinds
    assign wake = irqQ | watchdogResetReq | debugHaltIn | extResetReq
                | (intIn & (eeQ | ceQ));
    // Stop core zone on a new request only, so a lingering one is no retrigger
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            coreZoneClockEnable <= 1'h1;
            coreClockOffStatus  <= 1'h0;
        end else if (!coreClockOffStatus && sleepReq && !sleepQ) begin
            coreZoneClockEnable <= 1'h0;
            coreClockOffStatus  <= 1'h1;
        end else if (coreClockOffStatus && wake) begin
            coreZoneClockEnable <= 1'h1;
            coreClockOffStatus  <= 1'h0;
        end
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
    import cpu_clock_power_mgmt_pkg::*;
    logic clk_sys = 0, srst = 1, timerTick = 0, debugHaltIn = 0;
    logic msrWrite = 0, pipelineBusy = 0, wakeEvent = 0, pitLoad = 0;
    logic timerGate = 1, intIn = 0, extResetReq = 0, clkPark = 0;
    logic coreZoneClockEnable, timerZoneClockEnable, scanZoneClockEnable;
    logic coreClockOffStatus, extIrqEnableOut, critIrqEnableOut;
    logic timerIrqReq, watchdogResetReq, sleepReq;
    msr_t msrData = '0;
    timer_cfg_t timerCfg = '{32'h0, 1'h0, 6'h3F, 6'h3F, RST_NONE};
    timer_irq_t irqClear = '0, pendingIrq;
    debug_status_t debugStatus;
    logic [TB_W-1:0] timeBase, expTb = '0;
    logic [PIT_W-1:0] intervalCount, expPit = '0;
    int fails = 0, n_checks = 0, seed = 18659, k;

    // Parking holds the clock high, never low
    always #4 clk_sys = ~clk_sys | clkPark;

    cpu_clock_power_mgmt_port i_cpu_clock_power_mgmt_port (.clk_sys, .srst,
        .coreZoneClockEnable, .timerZoneClockEnable, .scanZoneClockEnable,
        .coreClockOffStatus, .timerTick, .debugHaltIn, .msrWrite, .msrData,
        .pipelineBusy, .wakeEvent, .pitLoad, .timerCfg, .irqClear,
        .extIrqEnableOut, .critIrqEnableOut, .timerIrqReq, .watchdogResetReq,
        .sleepReq, .debugStatus, .timeBase, .intervalCount, .pendingIrq);

    power_mgmt_model i_power_mgmt_model (.clk_sys, .srst, .sleepReq,
        .timerIrqReq, .watchdogResetReq, .extIrqEnableOut, .critIrqEnableOut,
        .intIn, .extResetReq, .debugHaltIn, .timerGate, .coreZoneClockEnable,
        .timerZoneClockEnable, .scanZoneClockEnable, .coreClockOffStatus);

    task automatic chk(input logic [63:0] seen, exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bounded wait; running out ends the run as a failure
    task automatic waitFor(ref logic s, input logic v);
        for (k = 0; k < 200 && s !== v; k++) @(posedge clk_sys) #1;
        if (s !== v) begin
            fails++;
            print_verdict();
        end
    endtask

    // Random ticks and gating, with the expected counts kept alongside
    task automatic runTicks(input int n);
        logic t, g;
        repeat (n) begin
            @(posedge clk_sys);
            t = 1'($random(seed));
            g = (($random(seed) & 3) != 0);
            timerTick <= t;
            timerGate <= g;
            if (t && g) begin
                expTb++;
                expPit = pitStep(expPit);
            end
        end
        @(posedge clk_sys);
        timerTick <= 0;
        timerGate <= 1;
        @(posedge clk_sys) #1;
    endtask

    // Interval counter after one tick: stops at zero, reloads when set
    function automatic logic [PIT_W-1:0] pitStep(input logic [PIT_W-1:0] c);
        if (c == '0) return c;
        if (c == PIT_W'(1) && timerCfg.autoReload) return timerCfg.reload;
        return c - PIT_W'(1);
    endfunction

    task automatic loadPit(input logic [PIT_W-1:0] v,
                           input logic reloadOn = 1'b0);
        @(posedge clk_sys);
        timerCfg.reload <= v;
        timerCfg.autoReload <= reloadOn;
        pitLoad <= 1;
        @(posedge clk_sys);
        pitLoad <= 0;
        expPit = v;
    endtask

    task automatic pulse(input msr_t v, input logic busy);
        @(posedge clk_sys);
        msrData <= v;
        msrWrite <= 1;
        pipelineBusy <= busy;
        @(posedge clk_sys);
        msrWrite <= 0;
        @(posedge clk_sys) #1;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        srst <= 0;
        #1 chk(sleepReq | timerIrqReq, 0, "reset");
        chk(watchdogResetReq, 0, "reset watchdog");
        for (int i = 0; i < 4; i++) begin
            pulse('{i[1], i[0], 1'b0}, 0);
            chk(extIrqEnableOut, i[1], "ext mirror");
            chk(critIrqEnableOut, i[0], "crit mirror");
        end
        $display("mirror test done");
        loadPit(32'h100 + PIT_W'($random(seed) & 32'hFF));
        runTicks(60);
        chk(timeBase, expTb, "time base");
        chk(intervalCount, expPit, "interval");
        loadPit(32'h3);
        runTicks(40);
        chk(intervalCount, expPit, "interval at zero");
        chk(timerIrqReq, 1, "timer request");
        chk(pendingIrq, 3'h4, "interval source");
        loadPit(32'h5, 1'b1);
        runTicks(50);
        chk(intervalCount, expPit, "interval reload");
        @(posedge clk_sys) irqClear <= '{1'b1, 1'b1, 1'b1};
        @(posedge clk_sys) irqClear <= '0;
        repeat (2) @(posedge clk_sys);
        #1 chk(timerIrqReq, 0, "request cleared");
        $display("timer test done");
        for (int src = 0; src < 4; src++) begin
            if (src == 1) loadPit(32'h4);
            pulse('{1'b1, 1'b0, 1'b1}, 1);
            repeat (5) @(posedge clk_sys);
            #1 chk(sleepReq, 0, "sleep while busy");
            @(posedge clk_sys) pipelineBusy <= 0;
            waitFor(sleepReq, 1);
            waitFor(coreClockOffStatus, 1);
            @(posedge clk_sys) #1;
            chk(debugStatus, 2'h3, "debug status");
            @(posedge clk_sys);
            debugHaltIn <= (src == 0);
            timerTick <= (src == 1);
            intIn <= (src == 2);
            extResetReq <= (src == 3);
            wakeEvent <= (src >= 2);
            waitFor(extIrqEnableOut, 0);
            chk(sleepReq, 1, "sleep held");
            chk(timerIrqReq, 0, "timer request on wake");
            @(posedge clk_sys) #1 chk(sleepReq, 0, "sleep drop");
            chk(extIrqEnableOut, 1, "mirror back");
            @(posedge clk_sys);
            {debugHaltIn, timerTick, intIn, extResetReq, wakeEvent} <= '0;
            irqClear <= '{1'b1, 1'b1, 1'b1};
            @(posedge clk_sys) irqClear <= '0;
        end
        $display("sleep test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            srst <= 1;
            timerCfg.wdtBit <= 6'h0;
            timerCfg.fitBit <= 6'h1;
            timerCfg.resetSel <= reset_sel_t'(i);
            @(posedge clk_sys) srst <= 0;
            @(posedge clk_sys) timerTick <= 1;
            repeat (8) @(posedge clk_sys);
            timerTick <= 0;
            repeat (3) @(posedge clk_sys);
            #1 chk(watchdogResetReq, i != 0, "watchdog request");
            chk(timerIrqReq, 1, "watchdog irq");
            chk(pendingIrq, 3'h3, "fixed and watchdog");
            chk(timeBase, 64'h8, "full rate");
        end
        $display("watchdog test done");
        // Global gating: clock parked high, so only two edges in 52 ns
        @(posedge clk_sys) timerTick <= 1;
        #1 expTb = timeBase + 64'h2;
        @(negedge clk_sys) clkPark = 1;
        #42 clkPark = 0;
        @(posedge clk_sys) #1 chk(timeBase, expTb, "parked clock");
        @(posedge clk_sys) timerTick <= 0;
        $display("park test done");
        print_verdict();
    end
endmodule
